// [common/nurl_consts.svh]
// Constants for the user row boot loader: offsets, field positions, defaults, fetch count.
// Assumes inclusion by the loader design file; definitions only.
// Operation
// - Bus address regions stay fixed; no remapping ever, booting included.
// - Page count and page size code are read-only parameter fields; 64-byte pages.
// - At startup each automatic calibration row value is copied to its register.
// - At power-on the first two user row words are read and applied as defaults.
// - User row stays readable by software at its fixed system address.
// - Rewritten user row reaches consumers only after the next device reset.
// - Bits 2:0 select loader guard size; erased default 0x7, one variant 0x3.
// - Bits 6:4 select EEPROM emulation size, default 7.
// - Bits 13:8 give droop detector level, default 7 or 34 for automotive.
// - Bit 14 droop detector enable, bits 16:15 its action, both default 1.
// - Bit 25 watchdog enable, bit 26 always-on, both default 0.
// - Bits 30:27 watchdog period, bits 34:31 window time-out, default 0x0B.
// - Bits 38:35 early warning offset default 0xB; bit 39 window enable default 0.
// - Bit 40 droop detector hysteresis, default 1.
// - Bits 63:48 region lock bits to the controller; 0xFFFF means all unlocked.
`ifndef NURL_CONSTS_SVH
`define NURL_CONSTS_SVH
// Fixed system addresses
`define NURL_USER_ROW_ADDR 24'h804000
`define NURL_CAL_ROW_ADDR 24'h806020
// APB register byte offsets
`define NURL_OFS_NVM_PARAMETER_REG 12'h000
`define NURL_OFS_USER_LO 12'h004
`define NURL_OFS_USER_HI 12'h008
`define NURL_OFS_STATUS 12'h00C
`define NURL_OFS_CAL0 12'h010
`define NURL_OFS_CAL1 12'h014
`define NURL_OFS_CAL2 12'h018
`define NURL_OFS_CAL3 12'h01C
// Flash geometry; code 0 means 8 bytes, so 64 bytes is code 3
`define NURL_PAGE_COUNT 16'h1000
`define NURL_PAGE_SIZE_CODE 3'h3
// Field positions in the 64-bit user row
`define NURL_GUARD_LSB 0
`define NURL_EEP_LSB 4
`define NURL_LVL_LSB 8
`define NURL_BEN_BIT 14
`define NURL_BACT_LSB 15
`define NURL_WEN_BIT 25
`define NURL_WAON_BIT 26
`define NURL_WPER_LSB 27
`define NURL_WWIN_LSB 31
`define NURL_EWO_LSB 35
`define NURL_WWEN_BIT 39
`define NURL_HYST_BIT 40
`define NURL_LOCK_LSB 48
// Erased defaults, applied while loading
`define NURL_DEF_GUARD 3'h7
`define NURL_DEF_GUARD_ALT 3'h3
`define NURL_DEF_EEP 3'h7
`define NURL_DEF_LVL 6'h07
`define NURL_DEF_LVL_AUTO 6'h22
`define NURL_DEF_BACT 2'h1
`define NURL_DEF_WPER 4'hB
`define NURL_DEF_WWIN 4'hB
`define NURL_DEF_EWO 4'hB
`define NURL_DEF_LOCK 16'hFFFF
// Number of words fetched: two user row words then four calibration words
`define NURL_FETCH_WORDS 3'h6
`endif

// [common/nurl_pkg.sv]
// Types for the user row boot loader.
// Assumes the constants header sits beside it.
package nurl_pkg;
  typedef enum logic [3:0] {
    NURL_IDLE = 4'h1,
    NURL_REQ = 4'h2,
    NURL_WAIT = 4'h4,
    NURL_DONE = 4'h8
  } nurl_state_t;
endpackage

// [design/nurl_loader.sv]
// User row and calibration row boot loader with APB view of captured values.
// Assumes a word-read port on the nonvolatile array answering with rd_valid.
`include "nurl_consts.svh"
module nurl_loader
  import nurl_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic variant_alt,
  input wire logic grade_auto,
  output logic nvm_rd_req,
  output logic [23:0] nvm_rd_addr,
  input wire logic nvm_rd_valid,
  input wire logic [31:0] nvm_rd_data,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic consumer_reset,
  output logic [2:0] loader_guard_size,
  output logic [2:0] eeprom_size,
  output logic [5:0] droop_level,
  output logic droop_enable,
  output logic [1:0] droop_action,
  output logic droop_hysteresis,
  output logic wdog_enable,
  output logic wdog_always_on,
  output logic [3:0] wdog_period,
  output logic [3:0] wdog_window,
  output logic [3:0] early_warning_offset,
  output logic wdog_window_enable,
  output logic [15:0] region_lock,
  output logic [127:0] cal_values
);

  ////////////////////////////////////////////////////////////////////////////
  // Fetch sequencer

  nurl_state_t state;
  nurl_state_t next_state;
  logic [2:0] word_idx;
  logic [63:0] user_row;
  logic [31:0] cal_word [0:3];
  logic [1:0] seen;

  // One pass per reset; the row is never fetched again, so rewrites wait
  always_comb begin
    next_state = state;
    case (state)
      NURL_IDLE: next_state = NURL_REQ;
      NURL_REQ: next_state = NURL_WAIT;
      NURL_WAIT: begin
        if (nvm_rd_valid) begin
          if (word_idx == `NURL_FETCH_WORDS - 3'h1) next_state = NURL_DONE;
          else next_state = NURL_REQ;
        end
      end
      NURL_DONE: next_state = NURL_DONE;
      default: next_state = NURL_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) state <= NURL_IDLE;
    else state <= next_state;
  end

  // Word counter advances on each answered read
  always_ff @(posedge clock or posedge reset) begin
    if (reset) word_idx <= 3'h0;
    else if (state == NURL_WAIT && nvm_rd_valid && state != NURL_DONE)
      word_idx <= word_idx + 3'h1;
  end

  // Request strobe and fixed addresses; no remap of any region
  assign nvm_rd_req = (state == NURL_REQ);
  always_comb begin
    if (word_idx < 3'h2)
      nvm_rd_addr = `NURL_USER_ROW_ADDR + {19'h0, word_idx, 2'h0};
    else
      nvm_rd_addr = `NURL_CAL_ROW_ADDR + {19'h0, word_idx - 3'h2, 2'h0};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture; defaults are held until the word actually arrives

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      user_row <= 64'h0;
      seen <= 2'h0;
    end else if (state == NURL_WAIT && nvm_rd_valid) begin
      if (word_idx == 3'h0) begin
        user_row[31:0] <= nvm_rd_data;
        seen[0] <= 1'b1;
      end else if (word_idx == 3'h1) begin
        user_row[63:32] <= nvm_rd_data;
        seen[1] <= 1'b1;
      end
    end
  end

  // Calibration words copied one per entry
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_cal
      always_ff @(posedge clock or posedge reset) begin
        if (reset) cal_word[gi] <= 32'h0;
        else if (state == NURL_WAIT && nvm_rd_valid && word_idx == 3'(gi + 2))
          cal_word[gi] <= nvm_rd_data;
      end
      assign cal_values[gi*32 +: 32] = cal_word[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Field decode to consumers; erased defaults until captured

  logic lo_ok;
  logic hi_ok;
  assign lo_ok = seen[0];
  assign hi_ok = seen[1];

  // Defaults before capture; strap inputs pick variant defaults
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      loader_guard_size <= `NURL_DEF_GUARD;
      eeprom_size <= `NURL_DEF_EEP;
      droop_level <= `NURL_DEF_LVL;
      droop_enable <= 1'b1;
      droop_action <= `NURL_DEF_BACT;
      wdog_enable <= 1'b0;
      wdog_always_on <= 1'b0;
      wdog_period <= `NURL_DEF_WPER;
    end else if (!lo_ok) begin
      loader_guard_size <= variant_alt ? `NURL_DEF_GUARD_ALT : `NURL_DEF_GUARD;
      droop_level <= grade_auto ? `NURL_DEF_LVL_AUTO : `NURL_DEF_LVL;
    end else begin
      loader_guard_size <= user_row[`NURL_GUARD_LSB +: 3];
      eeprom_size <= user_row[`NURL_EEP_LSB +: 3];
      droop_level <= user_row[`NURL_LVL_LSB +: 6];
      droop_enable <= user_row[`NURL_BEN_BIT];
      droop_action <= user_row[`NURL_BACT_LSB +: 2];
      wdog_enable <= user_row[`NURL_WEN_BIT];
      wdog_always_on <= user_row[`NURL_WAON_BIT];
      wdog_period <= user_row[`NURL_WPER_LSB +: 4];
    end
  end

  // Upper word fields; window field straddles both words
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wdog_window <= `NURL_DEF_WWIN;
      early_warning_offset <= `NURL_DEF_EWO;
      wdog_window_enable <= 1'b0;
      droop_hysteresis <= 1'b1;
      region_lock <= `NURL_DEF_LOCK;
    end else if (lo_ok && hi_ok) begin
      wdog_window <= user_row[`NURL_WWIN_LSB +: 4];
      early_warning_offset <= user_row[`NURL_EWO_LSB +: 4];
      wdog_window_enable <= user_row[`NURL_WWEN_BIT];
      droop_hysteresis <= user_row[`NURL_HYST_BIT];
      region_lock <= user_row[`NURL_LOCK_LSB +: 16];
    end
  end

  // Consumers stay in reset until all six words are in
  always_ff @(posedge clock or posedge reset) begin
    if (reset) consumer_reset <= 1'b1;
    else consumer_reset <= (state != NURL_DONE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, all registers read-only

  logic apb_acc;
  logic [31:0] next_prdata;
  logic next_err;
  assign apb_acc = psel && penable;
  assign pready = 1'b1;

  // Writes are refused so the parameter fields stay read-only
  always_comb begin
    next_err = 1'b0;
    next_prdata = 32'h0;
    if (pwrite) next_err = 1'b1;
    else if (paddr == `NURL_OFS_NVM_PARAMETER_REG)
      next_prdata = {13'h0, `NURL_PAGE_SIZE_CODE, `NURL_PAGE_COUNT};
    else if (paddr == `NURL_OFS_USER_LO) next_prdata = user_row[31:0];
    else if (paddr == `NURL_OFS_USER_HI) next_prdata = user_row[63:32];
    else if (paddr == `NURL_OFS_STATUS) next_prdata = {31'h0, state == NURL_DONE};
    else if (paddr == `NURL_OFS_CAL0) next_prdata = cal_word[0];
    else if (paddr == `NURL_OFS_CAL1) next_prdata = cal_word[1];
    else if (paddr == `NURL_OFS_CAL2) next_prdata = cal_word[2];
    else if (paddr == `NURL_OFS_CAL3) next_prdata = cal_word[3];
    else next_err = 1'b1;
  end

  // Read data is latched in the setup cycle, so it stands through the access phase
  always_ff @(posedge clock or posedge reset) begin
    if (reset) prdata <= 32'h0;
    else if (psel && !penable) prdata <= next_prdata;
    else if (!psel) prdata <= 32'h0;
  end

  // Error flag stays combinational; it qualifies the handshake like pready
  assign pslverr = apb_acc && next_err;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_answer;
    state == NURL_WAIT && nvm_rd_valid && word_idx == 3'h1;
  endsequence

  sequence s_answer_lo;
    state == NURL_WAIT && nvm_rd_valid && word_idx == 3'h0;
  endsequence

  sequence s_last_answer;
    state == NURL_WAIT && nvm_rd_valid && word_idx == 3'h5;
  endsequence

  sequence s_release;
    state == NURL_DONE ##1 !consumer_reset;
  endsequence

  a_load_hi_word: assert property (@(posedge clock) disable iff (reset)
    s_answer |=> user_row[63:32] == $past(nvm_rd_data))
    else $error("high user word not captured");

  a_defaults_lock: assert property (@(posedge clock) disable iff (reset)
    !hi_ok |-> region_lock == `NURL_DEF_LOCK)
    else $error("lock bits left default early");

  a_hold_consumers: assert property (@(posedge clock) disable iff (reset)
    state != NURL_DONE |=> consumer_reset)
    else $error("consumer released before load");

  a_no_reload: assert property (@(posedge clock) disable iff (reset)
    state == NURL_DONE |=> state == NURL_DONE && !nvm_rd_req)
    else $error("user row reloaded without reset");

  a_guard_apply: assert property (@(posedge clock) disable iff (reset)
    lo_ok |=> loader_guard_size == $past(user_row[2:0]))
    else $error("guard size not applied");

  a_eep_apply: assert property (@(posedge clock) disable iff (reset)
    lo_ok |=> eeprom_size == $past(user_row[6:4]))
    else $error("eeprom size not applied");

  a_level_apply: assert property (@(posedge clock) disable iff (reset)
    lo_ok |=> droop_level == $past(user_row[13:8]) && droop_enable == $past(user_row[14]))
    else $error("droop level not applied");

  a_wdog_apply: assert property (@(posedge clock) disable iff (reset)
    lo_ok && hi_ok |=> wdog_window == $past(user_row[34:31])
      && droop_hysteresis == $past(user_row[40]))
    else $error("watchdog window not applied");

  a_nvm_parameter_reg_ro: assert property (@(posedge clock) disable iff (reset)
    apb_acc && !pwrite && paddr == `NURL_OFS_NVM_PARAMETER_REG |-> prdata[18:16] == 3'h3
      && prdata[15:0] == 16'h1000)
    else $error("parameter field wrong");

  a_cal_copy: assert property (@(posedge clock) disable iff (reset)
    s_last_answer |=> cal_word[3] == $past(nvm_rd_data))
    else $error("calibration word not copied");

  // Fetch order, fixed addresses and the one-cycle request strobe
  a_lo_capture: assert property (@(posedge clock) disable iff (reset)
    s_answer_lo |=> user_row[31:0] == $past(nvm_rd_data))
    else $error("low user word not captured");

  a_next_word: assert property (@(posedge clock) disable iff (reset)
    s_answer_lo |=> nvm_rd_req && nvm_rd_addr == 24'h804004)
    else $error("second user word not requested next");

  a_release_done: assert property (@(posedge clock) disable iff (reset)
    s_last_answer |=> s_release)
    else $error("consumers not released after load");

  a_first_addr: assert property (@(posedge clock) disable iff (reset)
    state == NURL_REQ && word_idx == 3'h0 |-> nvm_rd_addr == `NURL_USER_ROW_ADDR)
    else $error("user row fetched from a moved address");

  a_cal_addr: assert property (@(posedge clock) disable iff (reset)
    state == NURL_REQ && word_idx == 3'h2 |-> nvm_rd_addr == `NURL_CAL_ROW_ADDR)
    else $error("calibration row fetched from a moved address");

  a_addr_stable: assert property (@(posedge clock) disable iff (reset)
    state == NURL_WAIT |-> $stable(nvm_rd_addr))
    else $error("fetch address moved while waiting");

  a_req_pulse: assert property (@(posedge clock) disable iff (reset)
    nvm_rd_req |=> !nvm_rd_req)
    else $error("read request longer than one cycle");

  // Hand-over of fields; the idle state is skipped because reset still rules there
  a_strap_defaults: assert property (@(posedge clock) disable iff (reset)
    state != NURL_IDLE && !lo_ok |=>
      loader_guard_size == ($past(variant_alt) ? `NURL_DEF_GUARD_ALT : `NURL_DEF_GUARD)
      && droop_level == ($past(grade_auto) ? `NURL_DEF_LVL_AUTO : `NURL_DEF_LVL))
    else $error("variant defaults not applied");

  a_upper_wait: assert property (@(posedge clock) disable iff (reset)
    !(lo_ok && hi_ok) |=> wdog_window == `NURL_DEF_WWIN)
    else $error("window time-out left default early");

  a_action_apply: assert property (@(posedge clock) disable iff (reset)
    lo_ok |=> droop_action == $past(user_row[16:15]))
    else $error("droop action not applied");

  a_wdog_en_apply: assert property (@(posedge clock) disable iff (reset)
    lo_ok |=> wdog_enable == $past(user_row[25])
      && wdog_always_on == $past(user_row[26]))
    else $error("watchdog enables not applied");

  a_period_apply: assert property (@(posedge clock) disable iff (reset)
    lo_ok |=> wdog_period == $past(user_row[30:27]))
    else $error("watchdog period not applied");

  a_ewo_apply: assert property (@(posedge clock) disable iff (reset)
    lo_ok && hi_ok |=> early_warning_offset == $past(user_row[38:35])
      && wdog_window_enable == $past(user_row[39]))
    else $error("early warning fields not applied");

  a_lock_apply: assert property (@(posedge clock) disable iff (reset)
    lo_ok && hi_ok |=> region_lock == $past(user_row[63:48]))
    else $error("region lock bits not applied");

  // Register view
  a_write_refused: assert property (@(posedge clock) disable iff (reset)
    apb_acc && pwrite |-> pslverr)
    else $error("write accepted on read-only view");

  a_unmapped_err: assert property (@(posedge clock) disable iff (reset)
    apb_acc && paddr > `NURL_OFS_CAL3 |-> pslverr)
    else $error("unmapped offset answered without error");

  a_user_view: assert property (@(posedge clock) disable iff (reset)
    state == NURL_DONE && apb_acc && !pwrite && paddr == `NURL_OFS_USER_LO
      |-> prdata == user_row[31:0])
    else $error("user row view differs from captured word");

endmodule // nurl_loader

// [bench/nurl_nvm_model.sv]
// Nonvolatile array model: returns one word per read after a set lag.
// Assumes one outstanding read at a time, as the loader issues them.
module nurl_nvm_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic [3:0] lag,
  input wire logic [63:0] user_row,
  input wire logic nvm_rd_req,
  input wire logic [23:0] nvm_rd_addr,
  output logic nvm_rd_valid,
  output logic [31:0] nvm_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy;
  logic [3:0] cnt;
  logic [23:0] adr;
  ////////////////////////////////////////////////////////////////////////////////
  // Cal words carry the low byte of their own address, so a wrong offset within the row shows up
  function automatic logic [31:0] word(input logic [23:0] a);
    if (a == 24'h804000) return user_row[31:0];
    if (a == 24'h804004) return user_row[63:32];
    return {24'hCA1B00, a[7:0]};
  endfunction
  // Read engine; data toggles whenever no word is presented
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      adr <= 24'h000000;
      nvm_rd_valid <= 1'b0;
      nvm_rd_data <= 32'h00000000;
    end else begin
      nvm_rd_valid <= 1'b0;
      nvm_rd_data <= ~nvm_rd_data;
      if (nvm_rd_req && !busy) begin
        busy <= 1'b1;
        cnt <= lag;
        adr <= nvm_rd_addr;
      end else if (busy && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (busy) begin
        busy <= 1'b0;
        nvm_rd_valid <= 1'b1;
        nvm_rd_data <= word(adr);
      end
    end
  end
endmodule // nurl_nvm_model

// [bench/nvm_user_row_boot_loader_tb.sv]
// Self-checking bench for the user row loader: load, APB view, rewrite, straps.
// Assumes the array model beside it and a zero-wait APB slave.
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module nvm_user_row_boot_loader_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] U1 = 64'hA5C3_0155_3A2E_9C5A;
  localparam logic [63:0] U2 = U1 ^ 64'hFFFF_01FF_FE01_FF77;
  localparam logic [63:0] DEF = 64'hFFFF_015D_D800_C777;
  localparam logic [63:0] DEF_S = 64'hFFFF_015D_D800_E273;
  localparam logic [127:0] CAL = 128'hCA1B002C_CA1B0028_CA1B0024_CA1B0020;
  logic clock, reset, variant_alt, grade_auto, nvm_rd_req, nvm_rd_valid, e;
  logic psel, penable, pwrite, pready, pslverr, consumer_reset, droop_enable;
  logic droop_hysteresis, wdog_enable, wdog_always_on, wdog_window_enable;
  logic [1:0] droop_action;
  logic [2:0] loader_guard_size, eeprom_size;
  logic [3:0] wdog_period, wdog_window, early_warning_offset, lag;
  logic [5:0] droop_level;
  logic [11:0] paddr;
  logic [15:0] region_lock;
  logic [23:0] nvm_rd_addr;
  logic [31:0] nvm_rd_data, pwdata, prdata, q;
  logic [63:0] user_row;
  logic [127:0] cal_values;
  int fails, samples_checked, cycles;
  nurl_loader dut_u (.clock, .reset, .variant_alt, .grade_auto, .nvm_rd_req, .nvm_rd_addr,
    .nvm_rd_valid, .nvm_rd_data, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .consumer_reset, .loader_guard_size, .eeprom_size, .droop_level, .droop_enable,
    .droop_action, .droop_hysteresis, .wdog_enable, .wdog_always_on, .wdog_period,
    .wdog_window, .early_warning_offset, .wdog_window_enable, .region_lock, .cal_values);
  nurl_nvm_model nvm_u (.clock, .reset, .lag, .user_row, .nvm_rd_req, .nvm_rd_addr,
    .nvm_rd_valid, .nvm_rd_data);
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and a cycle ceiling well above the few hundred cycles needed
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      conclude;
    end
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One APB transfer; released only after pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    // Only the cycle ceiling ends a wait that never sees pready
    while (pready !== 1'b1) @(posedge clock);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic fields(input logic [63:0] u);
    `CHK(loader_guard_size, u[2:0])
    `CHK(eeprom_size, u[6:4])
    `CHK(droop_level, u[13:8])
    `CHK(droop_enable, u[14])
    `CHK(droop_action, u[16:15])
    `CHK(wdog_enable, u[25])
    `CHK(wdog_always_on, u[26])
    `CHK(wdog_period, u[30:27])
    `CHK(wdog_window, u[34:31])
    `CHK(early_warning_offset, u[38:35])
    `CHK(wdog_window_enable, u[39])
    `CHK(droop_hysteresis, u[40])
    `CHK(region_lock, u[63:48])
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Wait for release of the consumers, then everything must already be applied
  task automatic t_load(input logic [63:0] u);
    int n;
    n = 0;
    while (consumer_reset !== 1'b0 && n < 400) begin
      @(posedge clock);
      n++;
    end
    `CHK(consumer_reset, 1'b0)
    `CHK(cal_values, CAL)
    fields(u);
    $display("test load done");
  endtask
  task automatic t_apb;
    apb(1'b0, 12'h000, 32'h0);
    `CHK(q, 32'h0003_1000)
    apb(1'b1, 12'h000, 32'hFFFF_FFFF);
    `CHK(e, 1'b1)
    apb(1'b0, 12'h000, 32'h0);
    `CHK(q, 32'h0003_1000)
    `CHK(e, 1'b0)
    apb(1'b0, 12'h004, 32'h0);
    `CHK(q, U1[31:0])
    apb(1'b0, 12'h008, 32'h0);
    `CHK(q, U1[63:32])
    apb(1'b0, 12'h00C, 32'h0);
    `CHK(q[0], 1'b1)
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'h010 + 12'(4 * i), 32'h0);
      `CHK(q, {24'hCA1B00, 8'h20 + 8'(4 * i)})
    end
    apb(1'b0, 12'h020, 32'h0);
    `CHK(e, 1'b1)
    $display("test apb done");
  endtask
  // Array rewritten behind the loader; only a reset may bring it in
  task automatic t_rewrite;
    user_row <= U2;
    lag <= 4'h7;
    repeat (20) @(posedge clock);
    fields(U1);
    apb(1'b0, 12'h004, 32'h0);
    `CHK(q, U1[31:0])
    reset <= 1'b1;
    @(posedge clock);
    reset <= 1'b0;
    t_load(U2);
    $display("test rewrite done");
  endtask
  // Straps choose the variant defaults while the slow array answers
  task automatic t_straps;
    variant_alt <= 1'b1;
    grade_auto <= 1'b1;
    lag <= 4'hF;
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    repeat (4) @(posedge clock);
    fields(DEF_S);
    `CHK(consumer_reset, 1'b1)
    t_load(U2);
    $display("test straps done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    reset = 1'b1;
    variant_alt = 1'b0;
    grade_auto = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    lag = 4'h0;
    user_row = U1;
    repeat (5) @(posedge clock);
    fields(DEF);
    `CHK(consumer_reset, 1'b1)
    reset <= 1'b0;
    t_load(U1);
    t_apb;
    t_rewrite;
    t_straps;
    conclude;
  end
endmodule // nvm_user_row_boot_loader_tb
